// *** mpp_core.sv ***
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////
// How it works
// - every flash, erase and lock write is timed by the write timer
// - two lock bits at bits 1 and 0, rest unused, only chip erase restores
// - lower lock bit programmed blocks serial memory writes, fuse writes and debug link
// - both lock bits programmed also blocks flash and eeprom readback
// - programmed debug fuse keeps program readback over debug link regardless of lock
// - programmed fuse or lock bit reads 0, unprogrammed 1; two fuse bytes
// - fuse high: self-program 4, debug 3, brown-out 2:1, reset disable 0
// - fuse low: serial 7, preserve 6, watchdog 5, div8 4, startup 3:2, clock 1:0
// - serial writes never change the serial programming enable fuse
// - programmed watchdog-always-on fuse disables the watchdog interrupt
// - chip erase leaves all fuse bits untouched
// - active fuses latched on entering programming, updated on leaving it
// - eeprom preserve fuse acts at once, without waiting for mode exit
// - all active fuses take their stored values at power-up reset
// - three signature bytes readable in programming mode even when locked
// - calibration byte loaded into oscillator calibration register during reset
// - flash is 32 pages of 16 words, word bits 3:0, page 8:4
// - eeprom is 16 pages of 4 bytes, byte bits 1:0, page 5:2
// - serial programming only with reset low and after programming enable
// - serial eeprom byte write overwrites target, no chip erase needed
// - chip erase sets flash and eeprom to all ones unless preserved
// - data in sampled on rising serial clock, out shifted on falling
// - second enable byte echoed during third byte when in sync
module mpp_core #(
  parameter int unsigned WRITE_CYCLES = mpp_pkg::WRITE_CYCLES
) (
  input logic clk,
  input logic sys_rst,
  input logic clk_en,
  input logic prog_rst_n,
  input logic sck,
  input logic mosi,
  output logic miso,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] fuse_low_active,
  output logic [7:0] fuse_high_active,
  output logic [7:0] oscillator_calibration_register,
  output logic wdt_irq_disable,
  output logic debug_link_enable,
  output logic debug_read_enable,
  output logic write_busy
);

  localparam int PW = mpp_pkg::PG_AW;
  localparam int EW = mpp_pkg::EE_PG_AW;

  logic [15:0] flash_mem [0:mpp_pkg::FL_WORDS-1];
  logic [7:0] ee_mem [0:mpp_pkg::EE_BYTES-1];
  logic [15:0] page_buf [0:mpp_pkg::PG_WORDS-1];
  logic [7:0] ee_buf [0:mpp_pkg::EE_PG_BYTES-1];
  logic [mpp_pkg::EE_PG_BYTES-1:0] ee_mask_q;
  logic [7:0] lock_q;
  logic [7:0] fuse_lo_q;
  logic [7:0] fuse_hi_q;
  logic [7:0] fuse_lo_act_q;
  logic [7:0] fuse_hi_act_q;
  logic [7:0] osc_cal_q;
  mpp_pkg::mpp_ser_t ser_q;
  logic sck_q;
  logic miso_q;
  logic [4:0] bit_cnt_q;
  logic [31:0] sh_in_q;
  logic [7:0] sh_out_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic wdt_dis_q;
  logic dbg_link_q;
  logic dbg_read_q;
  logic busy;
  logic sck_rise;
  logic sck_fall;
  logic frame_done;
  logic [31:0] sh_next;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] c3;
  logic [7:0] c4;
  logic [7:0] rd_byte;
  logic [15:0] fl_word;
  logic prog_enter;
  logic prog_leave;
  logic ser_cmd;
  logic mem_ok;
  logic fuse_ok;
  logic cpu_ok;
  logic do_erase;
  logic do_pg_erase;
  logic do_fl_load;
  logic do_fl_write;
  logic do_ee_write;
  logic do_ee_load;
  logic do_ee_pwrite;
  logic do_lock;
  logic do_fuse_lo;
  logic do_fuse_hi;
  logic wr_start;
  logic [mpp_pkg::PG_NUM_W-1:0] op_page;
  logic [1:0] lock_val;
  logic apb_acc;
  logic apb_wr;
  logic cpu_cmd_wr;
  logic cpu_buf_wr;
  logic addr_hit;
  logic [31:0] rdata;

  ////////////////////////////////////////////////////////////////////////
  // serial link, sampled with clk
  assign sck_rise = sck & ~sck_q;
  assign sck_fall = ~sck & sck_q;
  assign sh_next = {sh_in_q[30:0], mosi};
  assign frame_done = sck_rise && (bit_cnt_q == mpp_pkg::FRAME_LAST);
  assign c1 = sh_next[31:24];
  assign c2 = sh_next[23:16];
  assign c3 = sh_next[15:8];
  assign c4 = sh_next[7:0];
  assign prog_enter = (ser_q == mpp_pkg::SER_OFF) && !prog_rst_n;
  assign prog_leave = (ser_q != mpp_pkg::SER_OFF) && prog_rst_n;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_q <= 1'b0;
      bit_cnt_q <= '0;
      sh_in_q <= '0;
      sh_out_q <= '0;
      miso_q <= 1'b0;
    end else if (clk_en) begin
      sck_q <= sck;
      if (ser_q == mpp_pkg::SER_OFF || prog_rst_n) begin
        bit_cnt_q <= '0;
        sh_out_q <= '0;
        miso_q <= 1'b0;
      end else if (sck_rise) begin
        sh_in_q <= sh_next;
        bit_cnt_q <= bit_cnt_q + 5'h1;
        if (bit_cnt_q == mpp_pkg::BIT_LAST_B3) begin
          sh_out_q <= rd_byte;
        end else if (bit_cnt_q[2:0] == mpp_pkg::BYTE_LAST) begin
          sh_out_q <= sh_next[7:0];
        end
      end else if (sck_fall) begin
        miso_q <= sh_out_q[7];
        sh_out_q <= {sh_out_q[6:0], 1'b0};
      end
    end
  end

  // a garbled enable frame leaves the link waiting; the programmer resets
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ser_q <= mpp_pkg::SER_OFF;
    end else if (clk_en) begin
      case (ser_q)
        mpp_pkg::SER_OFF: begin
          if (!prog_rst_n) ser_q <= mpp_pkg::SER_WAIT;
        end
        mpp_pkg::SER_WAIT: begin
          if (prog_rst_n) begin
            ser_q <= mpp_pkg::SER_OFF;
          end else if (frame_done && c1 == mpp_pkg::OP_PROG_EN && c2 == mpp_pkg::OP2_PROG_EN
                       && !fuse_lo_act_q[mpp_pkg::FL_SERIAL_PROGRAM_ENABLE_FUSE]) begin
            ser_q <= mpp_pkg::SER_ACTIVE;
          end
        end
        mpp_pkg::SER_ACTIVE: begin
          if (prog_rst_n) ser_q <= mpp_pkg::SER_OFF;
        end
        default: ser_q <= mpp_pkg::SER_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read answer for the fourth byte
  assign fl_word = flash_mem[{c3[mpp_pkg::ADDR_HI_BIT], sh_next[7:0]}];

  always_comb begin
    rd_byte = mpp_pkg::ERASED_BYTE;
    case (c2)
      mpp_pkg::OP_RD_FL_LO: begin
        if (lock_q[1:0] != mpp_pkg::LOCK_ALL) rd_byte = fl_word[7:0];
      end
      mpp_pkg::OP_RD_FL_HI: begin
        if (lock_q[1:0] != mpp_pkg::LOCK_ALL) rd_byte = fl_word[15:8];
      end
      mpp_pkg::OP_RD_EE: begin
        if (lock_q[1:0] != mpp_pkg::LOCK_ALL) rd_byte = ee_mem[c4[mpp_pkg::EE_AW-1:0]];
      end
      mpp_pkg::OP_RD_LOCK: rd_byte = (c3 == mpp_pkg::OP2_FUSE_HI) ? fuse_hi_q : lock_q;
      mpp_pkg::OP_RD_FUSE_LO: rd_byte = fuse_lo_q;
      mpp_pkg::OP_RD_CAL: rd_byte = mpp_pkg::CAL_BYTE;
      mpp_pkg::OP_RD_SIG: begin
        case (c4[1:0])
          mpp_pkg::SIG_ADDR0: rd_byte = mpp_pkg::SIG_BYTE0;
          mpp_pkg::SIG_ADDR1: rd_byte = mpp_pkg::SIG_BYTE1;
          mpp_pkg::SIG_ADDR2: rd_byte = mpp_pkg::SIG_BYTE2;
          default: rd_byte = mpp_pkg::ERASED_BYTE;
        endcase
      end
      default: rd_byte = mpp_pkg::ERASED_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // operation decode, serial frames and cpu requests never overlap
  always_comb begin
    ser_cmd = frame_done && ser_q == mpp_pkg::SER_ACTIVE && !prog_rst_n;
    mem_ok = !busy && lock_q[1:0] == mpp_pkg::LOCK_NONE;
    fuse_ok = !busy && lock_q[mpp_pkg::LOCK_LOW_BIT];
    cpu_ok = cpu_cmd_wr && ser_q == mpp_pkg::SER_OFF && !busy
             && !fuse_hi_act_q[mpp_pkg::FH_SELFPRG];
    do_erase = ser_cmd && !busy && c1 == mpp_pkg::OP_PROG_EN
               && (c2 & mpp_pkg::OP2_ERASE_MASK) == mpp_pkg::OP2_ERASE;
    do_pg_erase = cpu_ok && pwdata[mpp_pkg::CMD_OP_LSB +: 2] == mpp_pkg::CPU_OP_ERASE;
    do_fl_load = ser_cmd && mem_ok
                 && (c1 == mpp_pkg::OP_LD_FL_LO || c1 == mpp_pkg::OP_LD_FL_HI);
    do_fl_write = (ser_cmd && mem_ok && c1 == mpp_pkg::OP_WR_FL_PAGE)
                  || (cpu_ok && pwdata[mpp_pkg::CMD_OP_LSB +: 2] == mpp_pkg::CPU_OP_WRITE);
    do_ee_write = ser_cmd && mem_ok && c1 == mpp_pkg::OP_WR_EE;
    do_ee_load = ser_cmd && mem_ok && c1 == mpp_pkg::OP_LD_EE_PAGE;
    do_ee_pwrite = ser_cmd && mem_ok && c1 == mpp_pkg::OP_WR_EE_PAGE;
    do_lock = (ser_cmd && !busy && c1 == mpp_pkg::OP_PROG_EN && c2 == mpp_pkg::OP2_WR_LOCK)
              || (cpu_ok && pwdata[mpp_pkg::CMD_OP_LSB +: 2] == mpp_pkg::CPU_OP_LOCK);
    do_fuse_lo = ser_cmd && fuse_ok && c1 == mpp_pkg::OP_PROG_EN
                 && c2 == mpp_pkg::OP2_WR_FUSE_LO;
    do_fuse_hi = ser_cmd && fuse_ok && c1 == mpp_pkg::OP_PROG_EN
                 && c2 == mpp_pkg::OP2_WR_FUSE_HI;
    wr_start = do_erase || do_pg_erase || do_fl_write || do_ee_write || do_ee_pwrite
               || do_lock || do_fuse_lo || do_fuse_hi;
    op_page = ser_cmd ? {c2[mpp_pkg::ADDR_HI_BIT], c3[7:PW]}
                      : pwdata[mpp_pkg::CMD_PAGE_LSB +: mpp_pkg::PG_NUM_W];
    lock_val = ser_cmd ? c4[1:0] : pwdata[mpp_pkg::CMD_LOCK_LSB +: 2];
  end

  mpp_timer #(
    .CYCLES(WRITE_CYCLES),
    .W(mpp_pkg::TIMER_W)
  ) u_timer (
    .clk(clk),
    .rst(sys_rst),
    .ce(clk_en),
    .start(wr_start),
    .busy(busy)
  );

  ////////////////////////////////////////////////////////////////////////
  // arrays; contents take effect at once, busy only guards the next write or serial buffer load
  always_ff @(posedge clk) begin
    if (clk_en) begin
      if (do_erase) begin
        for (int i = 0; i < mpp_pkg::FL_WORDS; i++) begin
          flash_mem[i] <= mpp_pkg::ERASED_WORD;
        end
        if (fuse_lo_q[mpp_pkg::FL_EEPROM_PRESERVE_FUSE]) begin
          for (int i = 0; i < mpp_pkg::EE_BYTES; i++) begin
            ee_mem[i] <= mpp_pkg::ERASED_BYTE;
          end
        end
      end
      if (do_pg_erase) begin
        for (int i = 0; i < mpp_pkg::PG_WORDS; i++) begin
          flash_mem[{op_page, PW'(i)}] <= mpp_pkg::ERASED_WORD;
        end
      end
      if (do_fl_write) begin
        for (int i = 0; i < mpp_pkg::PG_WORDS; i++) begin
          flash_mem[{op_page, PW'(i)}] <= page_buf[i];
          page_buf[i] <= mpp_pkg::ERASED_WORD;
        end
      end
      if (do_fl_load) begin
        if (c1 == mpp_pkg::OP_LD_FL_HI) begin
          page_buf[c3[PW-1:0]][15:8] <= c4;
        end else begin
          page_buf[c3[PW-1:0]][7:0] <= c4;
        end
      end
      if (cpu_buf_wr) begin
        page_buf[pwdata[mpp_pkg::BUF_IDX_LSB +: PW]] <= pwdata[15:0];
      end
      if (do_ee_write) begin
        ee_mem[c3[mpp_pkg::EE_AW-1:0]] <= c4;
      end
      if (do_ee_load) begin
        ee_buf[c3[EW-1:0]] <= c4;
      end
      if (do_ee_pwrite) begin
        for (int j = 0; j < mpp_pkg::EE_PG_BYTES; j++) begin
          if (ee_mask_q[j]) begin
            ee_mem[{c3[mpp_pkg::EE_AW-1:EW], EW'(j)}] <= ee_buf[j];
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ee_mask_q <= '0;
    end else if (clk_en) begin
      if (do_ee_pwrite) begin
        ee_mask_q <= '0;
      end else if (do_ee_load) begin
        ee_mask_q[c3[EW-1:0]] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // stored lock and fuse bytes; sys_rst stands for a blank part
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lock_q <= mpp_pkg::LOCK_RESET;
      fuse_lo_q <= mpp_pkg::FUSE_LO_RESET;
      fuse_hi_q <= mpp_pkg::FUSE_HI_RESET;
    end else if (clk_en) begin
      if (do_erase) begin
        lock_q <= mpp_pkg::LOCK_RESET;
      end else if (do_lock) begin
        lock_q[1:0] <= lock_q[1:0] & lock_val;
      end
      if (do_fuse_lo) begin
        fuse_lo_q <= {fuse_lo_q[mpp_pkg::FL_SERIAL_PROGRAM_ENABLE_FUSE], c4[mpp_pkg::FL_SERIAL_PROGRAM_ENABLE_FUSE-1:0]};
      end
      if (do_fuse_hi) begin
        fuse_hi_q <= c4 | ~mpp_pkg::FUSE_HI_USED;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fuse_lo_act_q <= mpp_pkg::FUSE_LO_RESET;
      fuse_hi_act_q <= mpp_pkg::FUSE_HI_RESET;
    end else if (clk_en) begin
      if (prog_enter || prog_leave) begin
        fuse_lo_act_q <= fuse_lo_q;
        fuse_hi_act_q <= fuse_hi_q;
      end else begin
        fuse_lo_act_q[mpp_pkg::FL_EEPROM_PRESERVE_FUSE] <= fuse_lo_q[mpp_pkg::FL_EEPROM_PRESERVE_FUSE];
      end
    end
  end

  // lock bits are not latched, so a new lock mode blocks the debug link at once
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdt_dis_q <= 1'b0;
      dbg_link_q <= 1'b0;
      dbg_read_q <= 1'b0;
    end else if (clk_en) begin
      wdt_dis_q <= !fuse_lo_act_q[mpp_pkg::FL_WATCHDOG_ALWAYS_ON_FUSE];
      dbg_link_q <= !fuse_hi_act_q[mpp_pkg::FH_DEBUG]
                    && lock_q[1:0] == mpp_pkg::LOCK_NONE;
      dbg_read_q <= !fuse_hi_act_q[mpp_pkg::FH_DEBUG];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state; writes land on the edge that ends the access
  always_comb begin
    apb_acc = psel && penable && !pready_q;
    apb_wr = psel && penable && pwrite && pready_q && !pslverr_q;
    cpu_cmd_wr = apb_wr && paddr == mpp_pkg::REG_CPU_CMD;
    cpu_buf_wr = apb_wr && paddr == mpp_pkg::REG_CPU_BUF && ser_q == mpp_pkg::SER_OFF;
    addr_hit = paddr == mpp_pkg::REG_STATUS || paddr == mpp_pkg::REG_FUSE
               || paddr == mpp_pkg::REG_OSCILLATOR_CALIBRATION_REGISTER || paddr == mpp_pkg::REG_CPU_CMD
               || paddr == mpp_pkg::REG_CPU_BUF;
    rdata = '0;
    case (paddr)
      mpp_pkg::REG_STATUS: begin
        rdata[mpp_pkg::ST_LOCK_LSB +: 2] = lock_q[1:0];
        rdata[mpp_pkg::ST_BUSY] = busy;
        rdata[mpp_pkg::ST_PROG] = ser_q != mpp_pkg::SER_OFF;
        rdata[mpp_pkg::ST_SYNC] = ser_q == mpp_pkg::SER_ACTIVE;
      end
      mpp_pkg::REG_FUSE: rdata = {fuse_hi_q, fuse_lo_q, fuse_hi_act_q, fuse_lo_act_q};
      mpp_pkg::REG_OSCILLATOR_CALIBRATION_REGISTER: rdata[7:0] = osc_cal_q;
      default: rdata = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
      osc_cal_q <= mpp_pkg::CAL_BYTE;
    end else if (clk_en) begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc && !addr_hit;
      prdata_q <= (apb_acc && !pwrite) ? rdata : '0;
      if (apb_wr && paddr == mpp_pkg::REG_OSCILLATOR_CALIBRATION_REGISTER) begin
        osc_cal_q <= pwdata[7:0];
      end
    end
  end

  assign miso = miso_q;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign fuse_low_active = fuse_lo_act_q;
  assign fuse_high_active = fuse_hi_act_q;
  assign oscillator_calibration_register = osc_cal_q;
  assign wdt_irq_disable = wdt_dis_q;
  assign debug_link_enable = dbg_link_q;
  assign debug_read_enable = dbg_read_q;
  assign write_busy = busy;

endmodule // mpp_core

// *** mpp_core_properties.sv ***
`timescale 1ns/1ns
module mpp_core_properties #(
  parameter int unsigned WRITE_CYCLES = 20
) (
  input logic clk,
  input logic sys_rst,
  input logic prog_rst_n,
  input logic psel,
  input logic penable,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [7:0] fuse_low_active,
  input logic [7:0] fuse_high_active,
  input logic [7:0] oscillator_calibration_register,
  input logic wdt_irq_disable,
  input logic debug_link_enable,
  input logic debug_read_enable,
  input logic write_busy
);
  logic [16:0] busy_cnt_q;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  always_ff @(posedge clk) begin
    if (sys_rst || !write_busy) begin
      busy_cnt_q <= 17'h0;
    end else begin
      busy_cnt_q <= busy_cnt_q + 17'h1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  reset_values_a: assert property ($fell(sys_rst) |-> fuse_low_active == 8'h6A
    && fuse_high_active == 8'hFF && oscillator_calibration_register == 8'h80)
    else $error("fuse or calibration value wrong after reset");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  addr_error_a: assert property (psel && penable && !pready && paddr > 8'h10
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  busy_length_a: assert property ($fell(write_busy) |-> busy_cnt_q == 17'(WRITE_CYCLES))
    else $error("write time wrong");
  wdt_off_a: assert property ((!fuse_low_active[5]) [*2] |-> wdt_irq_disable)
    else $error("watchdog interrupt not disabled");
  debug_off_a: assert property (fuse_high_active[3] [*2] |->
    !debug_read_enable && !debug_link_enable) else $error("debug link on with fuse clear");
  fuse_hold_a: assert property ((!prog_rst_n) [*3] |-> $stable(fuse_high_active)
    && $stable(fuse_low_active[5:0])) else $error("active fuses moved in programming");
endmodule // mpp_core_properties

bind mpp_core mpp_core_properties #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .clk(clk), .sys_rst(sys_rst), .prog_rst_n(prog_rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fuse_low_active(fuse_low_active), .fuse_high_active(fuse_high_active),
  .oscillator_calibration_register(oscillator_calibration_register),
  .wdt_irq_disable(wdt_irq_disable), .debug_link_enable(debug_link_enable),
  .debug_read_enable(debug_read_enable), .write_busy(write_busy)
);

// *** mpp_pkg.sv ***
package mpp_pkg;

  ////////////////////////////////////////////////////////////////////////
  // timing: clk stands in for the calibrated rc oscillator
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned WRITE_MIN_US = 3700;
  localparam int unsigned WRITE_MAX_US = 4500;
  // least time, rounded up to whole cycles
  localparam int unsigned WRITE_CYCLES = ((CLK_HZ / 1000) * WRITE_MIN_US + 999) / 1000;
  localparam int unsigned TIMER_W = 17;

  ////////////////////////////////////////////////////////////////////////
  // lock byte and fuse bytes, 0 = programmed
  localparam int LOCK_LOW_BIT = 0;
  localparam int LOCK_HIGH_BIT = 1;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [1:0] LOCK_NONE = 2'h3;
  localparam logic [1:0] LOCK_ALL = 2'h0;

  localparam int FH_SELFPRG = 4;
  localparam int FH_DEBUG = 3;
  localparam int FH_BOD1 = 2;
  localparam int FH_BOD0 = 1;
  localparam int FH_RSTDIS = 0;
  localparam logic [7:0] FUSE_HI_RESET = 8'hFF;
  localparam logic [7:0] FUSE_HI_USED = 8'h1F;

  localparam int FL_SERIAL_PROGRAM_ENABLE_FUSE = 7;
  localparam int FL_EEPROM_PRESERVE_FUSE = 6;
  localparam int FL_WATCHDOG_ALWAYS_ON_FUSE = 5;
  localparam int FL_CLOCK_DIVIDE_EIGHT_FUSE = 4;
  localparam logic [7:0] FUSE_LO_RESET = 8'h6A;

  ////////////////////////////////////////////////////////////////////////
  // memory geometry
  localparam int FL_WORDS = 512;
  localparam int PG_AW = 4;
  localparam int PG_WORDS = 16;
  localparam int PG_NUM_W = 5;
  localparam int EE_AW = 6;
  localparam int EE_BYTES = 64;
  localparam int EE_PG_AW = 2;
  localparam int EE_PG_BYTES = 4;
  localparam int ADDR_HI_BIT = 0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////
  // signature space; identity values are arbitrary
  localparam logic [7:0] SIG_BYTE0 = 8'h5A;
  localparam logic [7:0] SIG_BYTE1 = 8'hA5;
  localparam logic [7:0] SIG_BYTE2 = 8'h3C;
  localparam logic [7:0] CAL_BYTE = 8'h80;
  localparam logic [1:0] SIG_ADDR0 = 2'h0;
  localparam logic [1:0] SIG_ADDR1 = 2'h1;
  localparam logic [1:0] SIG_ADDR2 = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // serial frame and instruction codes
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [4:0] BIT_LAST_B3 = 5'h17;
  localparam logic [4:0] FRAME_LAST = 5'h1F;
  localparam logic [7:0] OP_PROG_EN = 8'hAC;
  localparam logic [7:0] OP2_PROG_EN = 8'h53;
  localparam logic [7:0] OP2_ERASE_MASK = 8'hE0;
  localparam logic [7:0] OP2_ERASE = 8'h80;
  localparam logic [7:0] OP2_WR_LOCK = 8'hE0;
  localparam logic [7:0] OP2_WR_FUSE_LO = 8'hA0;
  localparam logic [7:0] OP2_WR_FUSE_HI = 8'hA8;
  localparam logic [7:0] OP2_FUSE_HI = 8'h08;
  localparam logic [7:0] OP_RD_FL_LO = 8'h20;
  localparam logic [7:0] OP_RD_FL_HI = 8'h28;
  localparam logic [7:0] OP_LD_FL_LO = 8'h40;
  localparam logic [7:0] OP_LD_FL_HI = 8'h48;
  localparam logic [7:0] OP_WR_FL_PAGE = 8'h4C;
  localparam logic [7:0] OP_RD_EE = 8'hA0;
  localparam logic [7:0] OP_WR_EE = 8'hC0;
  localparam logic [7:0] OP_LD_EE_PAGE = 8'hC1;
  localparam logic [7:0] OP_WR_EE_PAGE = 8'hC2;
  localparam logic [7:0] OP_RD_LOCK = 8'h58;
  localparam logic [7:0] OP_RD_FUSE_LO = 8'h50;
  localparam logic [7:0] OP_RD_SIG = 8'h30;
  localparam logic [7:0] OP_RD_CAL = 8'h38;

  typedef enum logic [1:0] {
    SER_OFF = 2'b00,
    SER_WAIT = 2'b01,
    SER_ACTIVE = 2'b10
  } mpp_ser_t;

  ////////////////////////////////////////////////////////////////////////
  // apb register map
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_FUSE = 8'h04;
  localparam logic [7:0] REG_OSCILLATOR_CALIBRATION_REGISTER = 8'h08;
  localparam logic [7:0] REG_CPU_CMD = 8'h0C;
  localparam logic [7:0] REG_CPU_BUF = 8'h10;
  localparam int ST_LOCK_LSB = 0;
  localparam int ST_BUSY = 2;
  localparam int ST_PROG = 3;
  localparam int ST_SYNC = 4;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_PAGE_LSB = 8;
  localparam int CMD_LOCK_LSB = 16;
  localparam int BUF_IDX_LSB = 16;
  localparam logic [1:0] CPU_OP_ERASE = 2'h1;
  localparam logic [1:0] CPU_OP_WRITE = 2'h2;
  localparam logic [1:0] CPU_OP_LOCK = 2'h3;

endpackage

// *** mpp_prog_model.sv ***
`timescale 1ns/1ns
module mpp_prog_model (
  input logic clk,
  input logic miso,
  output logic prog_rst_n,
  output logic sck,
  output logic mosi,
  output logic done,
  output logic [31:0] rword
);
  initial begin
    prog_rst_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    done = 1'b0;
    rword = 32'h0;
  end
  task automatic mode(input logic rst_n);
    prog_rst_n <= rst_n;
    repeat (2) @(posedge clk);
  endtask
  // four clk per phase stays clear of the three-cycle floor
  task automatic xfer(input logic [31:0] w, input logic c);
    for (int i = 31; i >= 0; i--) begin
      mosi <= w[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      rword <= {rword[30:0], miso};
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    // released line shows the inverse, not a held value
    mosi <= ~w[0];
    done <= c;
    @(posedge clk);
    done <= 1'b0;
  endtask
endmodule // mpp_prog_model

// *** mpp_timer.sv ***
`timescale 1ns/1ns

module mpp_timer #(
  parameter int unsigned CYCLES = 16,
  parameter int unsigned W = 17
) (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic start,
  output logic busy
);

  logic [W-1:0] cnt_q;
  logic busy_q;

  // busy stays high for exactly CYCLES clock cycles; restart ignored meanwhile
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (ce) begin
      if (start && !busy_q) begin
        cnt_q <= W'(CYCLES);
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 1'b1;
        busy_q <= (cnt_q != W'(1));
      end
    end
  end

  assign busy = busy_q;

endmodule // mpp_timer

// *** testbench.sv ***
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rword, exp_v;
  logic pready, prog_rst_n, sck, mosi, miso, done;
  logic [31:0] exp_q [$];
  logic [7:0] rd;
  logic [7:0] sg [3] = '{mpp_pkg::SIG_BYTE0, mpp_pkg::SIG_BYTE1, mpp_pkg::SIG_BYTE2};
  int seed = 4190;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  mpp_core #(.WRITE_CYCLES(20)) dut (.clk(clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .prog_rst_n(prog_rst_n), .sck(sck), .mosi(mosi), .miso(miso), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .fuse_low_active(), .fuse_high_active(),
    .oscillator_calibration_register(), .wdt_irq_disable(), .debug_link_enable(),
    .debug_read_enable(), .write_busy());
  mpp_prog_model pm (.clk(clk), .miso(miso), .prog_rst_n(prog_rst_n), .sck(sck),
    .mosi(mosi), .done(done), .rword(rword));
  initial forever #25 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] want);
    total_checks++;
    if (seen !== want) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task stop_test;
    $display("checks=%0d errors=%0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // a read notes its expected word; d doubles as write data
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) exp_q.push_back(d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // only the last two bytes out are compared: echo and data
  task sx(input logic [31:0] w, input logic [15:0] e);
    if (e != 16'hFFFF) exp_q.push_back({16'h0, e});
    pm.xfer(w, e != 16'hFFFF);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      stop_test;
    end
    if ((pready && !pwrite) || done) begin
      exp_v = exp_q.pop_front();
      check(done ? {16'h0, rword[15:0]} : prdata, exp_v);
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(0, mpp_pkg::REG_FUSE, 32'hFF6AFF6A);
    apb(0, mpp_pkg::REG_STATUS, 32'h3);
    apb(0, mpp_pkg::REG_OSCILLATOR_CALIBRATION_REGISTER, 32'h80);
    rd = 8'($random(seed));
    apb(1, mpp_pkg::REG_OSCILLATOR_CALIBRATION_REGISTER, {24'h0, rd});
    apb(0, mpp_pkg::REG_OSCILLATOR_CALIBRATION_REGISTER, {24'h0, rd});
    apb(0, 8'hFC, 32'h0);
    pm.mode(1'b0);
    sx(32'hAC530000, 16'h53FF);
    sx(32'hACA0008A, 16'hFFFF);
    apb(0, mpp_pkg::REG_FUSE, 32'hFF0AFF2A);
    sx(32'h50000000, 16'h000A);
    sx({24'hC0000D, rd}, 16'hFFFF);
    sx(32'hA0000D00, {8'h00, rd});
    sx(32'h40000311, 16'hFFFF);
    sx(32'h48000322, 16'hFFFF);
    sx(32'h4C001000, 16'hFFFF);
    sx(32'h20001300, 16'h0011);
    sx(32'h28001300, 16'h0022);
    sx(32'hACE000FE, 16'hFFFF);
    sx({24'hC0000D, ~rd}, 16'hFFFF);
    sx(32'hA0000D00, {8'h00, rd});
    sx(32'hACA800F7, 16'hFFFF);
    sx(32'h58080000, 16'h08FF);
    sx(32'hACE000FC, 16'hFFFF);
    sx(32'h58000000, 16'h00FC);
    sx(32'h20001300, 16'h00FF);
    for (int i = 0; i < 3; i++) sx({16'h3000, 8'(i), 8'h00}, {8'h00, sg[i]});
    sx(32'h38000000, 16'h0080);
    sx(32'hAC800000, 16'hFFFF);
    sx(32'h20001300, 16'h00FF);
    sx(32'hA0000D00, {8'h00, rd});
    sx(32'hC1000255, 16'hFFFF);
    sx(32'hC2000C00, 16'hFFFF);
    sx(32'hA0000E00, 16'h0055);
    apb(0, mpp_pkg::REG_STATUS, 32'h1B);
    pm.mode(1'b1);
    apb(0, mpp_pkg::REG_FUSE, 32'hFF0AFF0A);
    stop_test;
  end
endmodule // testbench
